// ### design/dacc_pkg.sv
package dacc_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int unsigned ACC_W = 40;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned SHAMT_W = 6;
	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned GUARD_LO = 32;
	localparam int unsigned SIGN39 = 39;
	localparam int unsigned SIGN31 = 31;
	localparam int unsigned HI_LO = 16;
	localparam int unsigned HI_HI = 31;
	localparam int unsigned RND_BIT = 15;
	// ****************************************
	// constants
	// ****************************************
	localparam logic [39:0] SAT40_POS = 40'h7FFFFFFFFF;
	localparam logic [39:0] SAT40_NEG = 40'h8000000000;
	localparam logic [39:0] SAT32_POS = 40'h007FFFFFFF;
	localparam logic [39:0] SAT32_NEG = 40'hFF80000000;
	localparam logic [15:0] LOW_HALF = 16'h8000;
	localparam logic [15:0] DW_POS = 16'h7FFF;
	localparam logic [15:0] DW_NEG = 16'h8000;
	localparam logic [15:0] WB_STEP = 16'h0002;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [39:0] ACC_RST = 40'h0000000000;
	localparam logic [15:0] SHIFT_R_MAX = 16'h000F;
	// ****************************************
	// operations
	// ****************************************
	typedef enum logic [3:0] {
		DACC_NOP,
		DACC_ADD,
		DACC_SUB,
		DACC_LOAD,
		DACC_MAC,
		DACC_MSC,
		DACC_MPY,
		DACC_MPYN,
		DACC_ED,
		DACC_SQUARED_DIFFERENCE_ACCUMULATE_OP,
		DACC_STORE,
		DACC_STORE_RND,
		DACC_SHIFT
	} dacc_op_e;
endpackage : dacc_pkg

// ### design/dacc_round.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// round and data write saturation
// ****************************************
module dacc_round
	import dacc_pkg::*;
(
	input wire logic [39:0] acc_in,
	input wire logic round_in,
	input wire logic convergent_in,
	input wire logic sat_en_in,
	output logic [15:0] word_out
);
	logic inc;
	logic [24:0] sum;
	always_comb
	begin
		inc = 1'b0;
		if (round_in)
		begin
			if (acc_in[15:0] == LOW_HALF && convergent_in)
				inc = acc_in[HI_LO]; // [RULE_16]
			else
				inc = acc_in[RND_BIT]; // [RULE_15]
		end
		// truncation simply drops the low word [RULE_14]
		sum = acc_in[39:15] + {24'h000000, inc};
		if (!sat_en_in)
			word_out = sum[16:1]; // [RULE_19]
		else if (!acc_in[SIGN39] && sum[24:16] != 9'h000)
			word_out = DW_POS; // [RULE_18]
		else if (acc_in[SIGN39] && sum[24:16] != 9'h1FF)
			word_out = DW_NEG; // [RULE_18]
		else
			word_out = sum[16:1];
	end
endmodule : dacc_round
`default_nettype wire

// ### design/dacc_top.sv
// Contract
// RULE_01: 40-bit adder, one accumulator source and destination
// RULE_02: add true with carry, subtract complement borrow
// RULE_03: guard flag set when bits 39:32 differ; here not set by an operation that also sets the saturation flag
// RULE_04: combined flags are OR of both
// RULE_05: sticky saturation flag, cleared by software
// RULE_06: guard overflow with trap enable raises trap
// RULE_07: saturation off: catastrophic flag may trap
// RULE_08: saturation uses enables and width select
// RULE_09: 40-bit mode clamps to 9.31 extremes
// RULE_10: 32-bit mode clamps, guard flags stay clear
// RULE_11: saturation off lets accumulator wrap
// RULE_12: multiply-accumulate writes back other accumulator high
// RULE_13: write-back direct or indirect plus two
// RULE_14: round mode select, else truncate
// RULE_15: conventional round increments on low bit 15
// RULE_16: convergent tie looks at bit 16
// RULE_17: store truncated or rounded, write-back rounded
// RULE_18: data write saturation clamps stored word
// RULE_19: without it, word passes unmodified
// RULE_20: one-cycle shift, right 15, left 16
// RULE_21: signed amount, positive right, negative left
// RULE_22: x bus enters 16..31 right, 0..15 left
//
// Chosen here: the strobed write-back pointer register port.
`timescale 1ns/1ps
`default_nettype none
module dacc_top
	import dacc_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic op_valid_in,
	input wire dacc_op_e op_in,
	input wire logic target_two_in,
	input wire logic [39:0] product_in,
	input wire logic [15:0] x_bus_in,
	input wire logic shift_src_x_in,
	input wire logic shift_src_two_in,
	input wire logic shift_logical_in,
	input wire logic signed [5:0] shift_amt_in,
	input wire logic load_shift_in,
	input wire logic wb_en_in,
	input wire logic wb_indirect_in,
	input wire logic saturation_enable_one_in,
	input wire logic saturation_enable_two_in,
	input wire logic saturation_width_select_in,
	input wire logic round_mode_select_in,
	input wire logic data_write_saturation_enable_in,
	input wire logic overflow_trap_enable_one_in,
	input wire logic overflow_trap_enable_two_in,
	input wire logic catastrophic_overflow_trap_enable_in,
	input wire logic sat_clear_one_in,
	input wire logic sat_clear_two_in,
	input wire logic ptr_wr_in,
	input wire logic [15:0] ptr_wdata_in,
	output logic [39:0] accumulator_one_out,
	output logic [39:0] accumulator_two_out,
	output logic guard_overflow_flag_one_out,
	output logic guard_overflow_flag_two_out,
	output logic saturation_flag_one_out,
	output logic saturation_flag_two_out,
	output logic combined_guard_overflow_flag_out,
	output logic combined_saturation_flag_out,
	output logic trap_req_out,
	output logic [15:0] write_back_pointer_register_out,
	output logic mem_wr_out,
	output logic [15:0] mem_addr_out,
	output logic [15:0] mem_wdata_out,
	output logic [39:0] shift_result_out,
	output logic [15:0] shift_word_out
);
	// ****************************************
	// state
	// ****************************************
	logic [39:0] acc_r [2];
	logic [1:0] guard_r;
	logic [1:0] sat_r;
	logic trap_r;
	logic [15:0] ptr_r;
	logic mem_wr_r;
	logic [15:0] mem_addr_r;
	logic [15:0] mem_wdata_r;
	logic [39:0] shres_r;
	logic [15:0] shword_r;
	// ****************************************
	// barrel shifter
	// ****************************************
	logic [39:0] sh_src;
	logic [39:0] sh_out;
	logic [5:0] sh_mag;
	logic sh_left;
	always_comb
	begin
		sh_left = shift_amt_in[5]; // [RULE_21]
		sh_mag = sh_left ? 6'(-shift_amt_in) : {1'b0, shift_amt_in[4:0]};
		if (shift_src_x_in)
		begin
			// x bus placed per direction [RULE_22]
			if (sh_left)
				sh_src = {24'h000000, x_bus_in};
			else
				sh_src = {{8{x_bus_in[15]}}, x_bus_in, 16'h0000};
		end
		else
			sh_src = shift_src_two_in ? acc_r[1] : acc_r[0]; // [RULE_20]
		// out of range magnitudes are not defined by the ISA; clamp keeps one cycle
		if (shift_amt_in == 6'sd0)
			sh_out = sh_src; // [RULE_21]
		else if (sh_left)
			sh_out = sh_src << ((sh_mag > 6'd16) ? 6'd16 : sh_mag); // [RULE_20]
		else if (shift_logical_in)
			sh_out = sh_src >> ((sh_mag > 6'd15) ? 6'd15 : sh_mag);
		else
			sh_out = 40'($signed(sh_src) >>> ((sh_mag > 6'd15) ? 6'd15 : sh_mag));
	end
	// ****************************************
	// adder and saturation
	// ****************************************
	logic tgt;
	logic [39:0] acc_t;
	logic [39:0] opnd;
	logic [39:0] side_a;
	logic [39:0] side_b;
	logic cin;
	logic [40:0] sum;
	logic [39:0] res;
	logic adder_used;
	logic ovf39;
	logic ovf31;
	logic guard_bad;
	logic sat_on;
	logic wide_mode;
	logic [39:0] acc_nxt;
	logic sat_hit;
	always_comb
	begin
		tgt = target_two_in;
		acc_t = tgt ? acc_r[1] : acc_r[0];
		opnd = load_shift_in ? sh_out : product_in; // [RULE_01]
		side_a = acc_t;
		side_b = opnd;
		cin = 1'b0;
		adder_used = op_valid_in;
		unique case (op_in)
			DACC_ADD, DACC_MAC, DACC_SQUARED_DIFFERENCE_ACCUMULATE_OP:
			begin
				side_b = opnd; // [RULE_02]
				cin = 1'b0;
			end
			DACC_SUB, DACC_MSC:
			begin
				side_b = ~opnd; // [RULE_02]
				cin = 1'b1;
			end
			DACC_LOAD, DACC_MPY, DACC_ED:
				side_a = ACC_RST; // zero input side [RULE_02]
			DACC_MPYN:
			begin
				side_a = ACC_RST;
				side_b = ~opnd;
				cin = 1'b1;
			end
			default:
				adder_used = 1'b0;
		endcase
		sum = {1'b0, side_a} + {1'b0, side_b} + {40'h0000000000, cin}; // [RULE_01]
		res = sum[39:0];
		// sign overflow: like-signed inputs give unlike result
		ovf39 = (side_a[SIGN39] == side_b[SIGN39]) && (res[SIGN39] != side_a[SIGN39]);
		guard_bad = !((&res[39:GUARD_LO]) || !(|res[39:GUARD_LO])); // [RULE_03]
		ovf31 = ovf39 || (res[39:SIGN31] != {9{res[SIGN39]}});
		sat_on = tgt ? saturation_enable_two_in : saturation_enable_one_in; // [RULE_08]
		wide_mode = saturation_width_select_in; // [RULE_08]
		acc_nxt = res;
		sat_hit = 1'b0;
		if (sat_on && wide_mode && ovf39)
		begin
			acc_nxt = side_a[SIGN39] ? SAT40_NEG : SAT40_POS; // [RULE_09]
			sat_hit = 1'b1;
		end
		else if (sat_on && !wide_mode && ovf31)
		begin
			// true sign from the 41-bit view of the wrapped result
			acc_nxt = (ovf39 ? side_a[SIGN39] : res[SIGN39]) ? SAT32_NEG : SAT32_POS; // [RULE_10]
			sat_hit = 1'b1;
		end
		else if (!sat_on && ovf39)
			sat_hit = 1'b1; // wrap kept [RULE_11] [RULE_07]
	end
	logic guard_set;
	assign guard_set = guard_bad && !(sat_on && !wide_mode) && !sat_hit; // [RULE_10]
	// ****************************************
	// accumulators
	// ****************************************
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			acc_r[0] <= ACC_RST;
			acc_r[1] <= ACC_RST;
		end
		else if (adder_used)
			acc_r[tgt] <= acc_nxt; // [RULE_01]
	end
	// ****************************************
	// flags
	// ****************************************
	logic [1:0] sat_clr;
	logic [1:0] guard_nxt;
	logic [1:0] sat_set;
	logic [1:0] sat_nxt;
	logic comb_guard_r;
	logic comb_sat_r;
	assign sat_clr = {sat_clear_two_in, sat_clear_one_in};
	always_comb
	begin
		guard_nxt = guard_r;
		sat_set = 2'b00;
		if (adder_used)
		begin
			guard_nxt[tgt] = guard_set; // [RULE_03]
			sat_set[tgt] = sat_hit; // [RULE_05]
		end
		// set wins over a clear in the same cycle, so no overflow is ever lost
		sat_nxt = sat_set | (sat_r & ~sat_clr); // [RULE_05]
	end
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			guard_r <= 2'b00;
		else
			guard_r <= guard_nxt; // [RULE_03]
	end
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			sat_r <= 2'b00;
		else
			sat_r <= sat_nxt; // [RULE_05]
	end
	// ****************************************
	// combined flags
	// ****************************************
	// registered from the next values so both views change on the same edge
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			comb_guard_r <= 1'b0;
			comb_sat_r <= 1'b0;
		end
		else
		begin
			comb_guard_r <= |guard_nxt; // [RULE_04]
			comb_sat_r <= |sat_nxt; // [RULE_04]
		end
	end
	logic guard_trap;
	logic cat_trap;
	assign guard_trap = adder_used && guard_set && !guard_r[tgt]
		&& (tgt ? overflow_trap_enable_two_in : overflow_trap_enable_one_in);
	assign cat_trap = adder_used && !sat_on && ovf39 && catastrophic_overflow_trap_enable_in;
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			trap_r <= 1'b0;
		else
			trap_r <= guard_trap || cat_trap; // one-cycle request [RULE_06] [RULE_07]
	end
	// ****************************************
	// store and write-back
	// ****************************************
	logic is_store;
	logic is_wb;
	logic [39:0] st_src;
	logic st_round;
	logic [15:0] st_word;
	assign is_store = op_valid_in && (op_in == DACC_STORE || op_in == DACC_STORE_RND);
	assign is_wb = op_valid_in && wb_en_in && (op_in == DACC_MAC || op_in == DACC_MSC); // [RULE_12]
	assign st_src = (is_store ? tgt : !tgt) ? acc_r[1] : acc_r[0]; // [RULE_12]
	assign st_round = is_wb || op_in == DACC_STORE_RND; // [RULE_17]
	dacc_round dacc_round_inst (
		.acc_in(st_src),
		.round_in(st_round),
		.convergent_in(round_mode_select_in),
		.sat_en_in(data_write_saturation_enable_in),
		.word_out(st_word)
	);
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			ptr_r <= PTR_RST;
		else if (is_wb && !wb_indirect_in)
			ptr_r <= st_word; // register direct [RULE_13]
		else if (is_wb && wb_indirect_in)
			ptr_r <= ptr_r + WB_STEP; // post increment [RULE_13]
		else if (ptr_wr_in)
			ptr_r <= ptr_wdata_in;
	end
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			mem_wr_r <= 1'b0;
			mem_addr_r <= PTR_RST;
			mem_wdata_r <= 16'h0000;
		end
		else
		begin
			mem_wr_r <= is_store || (is_wb && wb_indirect_in); // [RULE_17]
			mem_addr_r <= is_store ? x_bus_in : ptr_r;
			mem_wdata_r <= st_word;
		end
	end
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			shres_r <= ACC_RST;
			shword_r <= 16'h0000;
		end
		else if (op_valid_in && op_in == DACC_SHIFT)
		begin
			shres_r <= sh_out; // [RULE_22]
			shword_r <= sh_left ? sh_out[15:0] : sh_out[31:16];
		end
	end
	// ****************************************
	// outputs
	// ****************************************
	assign accumulator_one_out = acc_r[0];
	assign accumulator_two_out = acc_r[1];
	assign guard_overflow_flag_one_out = guard_r[0];
	assign guard_overflow_flag_two_out = guard_r[1];
	assign saturation_flag_one_out = sat_r[0];
	assign saturation_flag_two_out = sat_r[1];
	assign combined_guard_overflow_flag_out = comb_guard_r; // [RULE_04]
	assign combined_saturation_flag_out = comb_sat_r; // [RULE_04]
	assign trap_req_out = trap_r;
	assign write_back_pointer_register_out = ptr_r;
	assign mem_wr_out = mem_wr_r;
	assign mem_addr_out = mem_addr_r;
	assign mem_wdata_out = mem_wdata_r;
	assign shift_result_out = shres_r;
	assign shift_word_out = shword_r;
endmodule : dacc_top
`default_nettype wire

// ### testbench/dacc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module dacc_monitor
	import dacc_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic op_valid_in,
	input wire dacc_op_e op_in,
	input wire logic target_two_in,
	input wire logic saturation_enable_one_in,
	input wire logic saturation_width_select_in,
	input wire logic overflow_trap_enable_one_in,
	input wire logic sat_clear_one_in,
	input wire logic wb_en_in,
	input wire logic wb_indirect_in,
	input wire logic ptr_wr_in,
	input wire logic signed [5:0] shift_amt_in,
	input wire logic shift_src_x_in,
	input wire logic shift_src_two_in,
	input wire logic [39:0] accumulator_one_out,
	input wire logic guard_overflow_flag_one_out,
	input wire logic guard_overflow_flag_two_out,
	input wire logic saturation_flag_one_out,
	input wire logic saturation_flag_two_out,
	input wire logic combined_guard_overflow_flag_out,
	input wire logic combined_saturation_flag_out,
	input wire logic trap_req_out,
	input wire logic [15:0] write_back_pointer_register_out,
	input wire logic mem_wr_out,
	input wire logic [15:0] mem_addr_out,
	input wire logic [39:0] shift_result_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);
	logic add32_one;
	assign add32_one = op_valid_in && !target_two_in && saturation_enable_one_in
		&& !saturation_width_select_in && op_in inside {DACC_ADD, DACC_SUB, DACC_LOAD};
	comb_guard_a: assert property (combined_guard_overflow_flag_out ==
		(guard_overflow_flag_one_out | guard_overflow_flag_two_out)) else $error("guard or wrong");
	comb_sat_a: assert property (combined_saturation_flag_out ==
		(saturation_flag_one_out | saturation_flag_two_out)) else $error("sat or wrong");
	sat_sticky_a: assert property (saturation_flag_one_out && !sat_clear_one_in |=>
		saturation_flag_one_out) else $error("sat flag dropped");
	guard32_a: assert property (add32_one |=> !guard_overflow_flag_one_out)
		else $error("guard set in 32-bit mode");
	clamp32_a: assert property (add32_one |=>
		accumulator_one_out[39:31] == {9{accumulator_one_out[31]}}) else $error("no 32-bit clamp");
	guard_trap_a: assert property ($rose(guard_overflow_flag_one_out)
		&& overflow_trap_enable_one_in |-> trap_req_out) else $error("no guard trap");
	wb_step_a: assert property (op_valid_in && op_in == DACC_MAC && wb_en_in && wb_indirect_in
		&& !ptr_wr_in |=> mem_wr_out && mem_addr_out == $past(write_back_pointer_register_out)
		&& write_back_pointer_register_out == $past(write_back_pointer_register_out) + WB_STEP)
		else $error("indirect write-back wrong");
	no_wb_a: assert property (op_valid_in && op_in inside {DACC_MPY, DACC_MPYN, DACC_ED,
		DACC_SQUARED_DIFFERENCE_ACCUMULATE_OP} |=> !mem_wr_out) else $error("write-back on excluded op");
	shift_zero_a: assert property (op_valid_in && op_in == DACC_SHIFT && shift_amt_in == 0
		&& !shift_src_x_in && !shift_src_two_in |=> shift_result_out == $past(accumulator_one_out))
		else $error("zero shift changed operand");
	cover property ($rose(saturation_flag_one_out));
	cover property (trap_req_out);
	cover property (mem_wr_out);
endmodule : dacc_monitor
bind dacc_top dacc_monitor dacc_monitor_inst (.*);
`default_nettype wire

// ### testbench/dacc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// data memory seen over the x bus
// ****************************************
module dacc_mem_model
(
	input wire logic clk_in,
	input wire logic wr_in,
	input wire logic [15:0] addr_in,
	input wire logic [15:0] data_in,
	output logic [15:0] last_addr_out,
	output logic [15:0] last_data_out
);
	// only the last word is kept: enough for one store checked at a time
	always_ff @(posedge clk_in)
		if (wr_in)
		begin
			last_addr_out <= addr_in;
			last_data_out <= data_in;
		end
endmodule : dacc_mem_model
`default_nettype wire

// ### testbench/dacc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dacc_top_tb_top;
	import dacc_pkg::*;
	logic clk_in, arst_n_in, op_valid_in, target_two_in, shift_src_x_in, shift_src_two_in;
	logic shift_logical_in, load_shift_in, wb_en_in, wb_indirect_in, saturation_enable_one_in;
	logic saturation_enable_two_in, saturation_width_select_in, round_mode_select_in;
	logic data_write_saturation_enable_in, overflow_trap_enable_one_in, ptr_wr_in;
	logic overflow_trap_enable_two_in, catastrophic_overflow_trap_enable_in;
	logic sat_clear_one_in, sat_clear_two_in, guard_overflow_flag_one_out, trap_req_out;
	logic guard_overflow_flag_two_out, saturation_flag_one_out, saturation_flag_two_out;
	logic combined_guard_overflow_flag_out, combined_saturation_flag_out, mem_wr_out;
	logic [39:0] product_in, accumulator_one_out, accumulator_two_out, shift_result_out;
	logic [15:0] x_bus_in, ptr_wdata_in, write_back_pointer_register_out, mem_addr_out;
	logic [15:0] mem_wdata_out, shift_word_out, last_addr, last_data;
	logic signed [5:0] shift_amt_in;
	dacc_op_e op_in;
	int fails, checks_done;
	dacc_top dacc_top_inst (.*);
	dacc_mem_model dacc_mem_model_inst (.clk_in(clk_in), .wr_in(mem_wr_out),
		.addr_in(mem_addr_out), .data_in(mem_wdata_out), .last_addr_out(last_addr),
		.last_data_out(last_data));
	always #2.5 clk_in = ~clk_in;
	task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
		checks_done++;
		if (got !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask : chk
	task automatic do_op(input dacc_op_e o, input logic tgt, input logic [39:0] p);
		@(posedge clk_in);
		op_valid_in <= 1'b1;
		op_in <= o;
		target_two_in <= tgt;
		product_in <= p;
		@(posedge clk_in);
		op_valid_in <= 1'b0;
		#1;
	endtask : do_op
	task automatic cfg(input logic se, input logic w40, input logic cov, input logic ovt);
		@(posedge clk_in);
		saturation_enable_one_in <= se;
		saturation_width_select_in <= w40;
		catastrophic_overflow_trap_enable_in <= cov;
		overflow_trap_enable_one_in <= ovt;
		sat_clear_one_in <= 1'b1;
		sat_clear_two_in <= 1'b1;
		@(posedge clk_in);
		sat_clear_one_in <= 1'b0;
		sat_clear_two_in <= 1'b0;
	endtask : cfg
	task automatic st(input logic [39:0] a, input dacc_op_e o, input logic rnd, input logic dw,
		input logic [15:0] exp);
		@(posedge clk_in);
		round_mode_select_in <= rnd;
		data_write_saturation_enable_in <= dw;
		do_op(DACC_LOAD, 1'b0, a);
		do_op(o, 1'b0, 40'h0000000000);
		chk("store strobe", 40'h1, {39'h0, mem_wr_out});
		chk("store addr", {24'h0, x_bus_in}, {24'h0, mem_addr_out});
		@(posedge clk_in);
		#1;
		chk("stored word", {24'h0, exp}, {24'h0, last_data});
	endtask : st
	task automatic sh(input logic sx, input logic two, input logic lg,
		input logic signed [5:0] amt, input logic [39:0] exp);
		logic [15:0] wexp;
		// 16-bit result: low word after a left shift, bits 31:16 otherwise
		wexp = amt[5] ? exp[15:0] : exp[31:16];
		@(posedge clk_in);
		shift_src_x_in <= sx;
		shift_src_two_in <= two;
		shift_logical_in <= lg;
		shift_amt_in <= amt;
		do_op(DACC_SHIFT, 1'b0, 40'h0000000000);
		chk("shift result", exp, shift_result_out);
		chk("shift word", {24'h0, wexp}, {24'h0, shift_word_out});
	endtask : sh
	task automatic sc_sat40;
		cfg(1'b1, 1'b1, 1'b0, 1'b0);
		do_op(DACC_LOAD, 1'b0, 40'h7FFFFFFFF0);
		do_op(DACC_ADD, 1'b0, 40'h0000000020);
		chk("acc one", SAT40_POS, accumulator_one_out);
		chk("sat flag", 40'h1, {39'h0, combined_saturation_flag_out});
	endtask : sc_sat40
	task automatic sc_sat32;
		cfg(1'b1, 1'b0, 1'b0, 1'b0);
		do_op(DACC_LOAD, 1'b0, 40'h0080000000);
		chk("acc one", SAT32_POS, accumulator_one_out);
		do_op(DACC_LOAD, 1'b0, 40'hFF00000000);
		chk("acc one", SAT32_NEG, accumulator_one_out);
		chk("sat flag", 40'h1, {39'h0, saturation_flag_one_out});
	endtask : sc_sat32
	task automatic sc_wrap;
		cfg(1'b0, 1'b1, 1'b1, 1'b0);
		do_op(DACC_LOAD, 1'b0, 40'h7FFFFFFFF0);
		do_op(DACC_ADD, 1'b0, 40'h0000000020);
		chk("acc one", 40'h8000000010, accumulator_one_out);
		chk("sat flag", 40'h1, {39'h0, saturation_flag_one_out});
		chk("trap", 40'h1, {39'h0, trap_req_out});
	endtask : sc_wrap
	task automatic sc_guard;
		cfg(1'b0, 1'b1, 1'b0, 1'b0);
		do_op(DACC_LOAD, 1'b0, 40'h0000000000);
		cfg(1'b0, 1'b1, 1'b0, 1'b1);
		do_op(DACC_LOAD, 1'b0, 40'h0100000000);
		chk("guard", 40'h1, {39'h0, combined_guard_overflow_flag_out});
		chk("trap", 40'h1, {39'h0, trap_req_out});
		do_op(DACC_SUB, 1'b0, 40'h0100000000);
		chk("acc one", 40'h0, accumulator_one_out);
		chk("guard", 40'h0, {39'h0, guard_overflow_flag_one_out});
	endtask : sc_guard
	task automatic sc_store;
		st(40'h0000018000, DACC_STORE, 1'b0, 1'b0, 16'h0001);
		st(40'h0000018000, DACC_STORE_RND, 1'b0, 1'b0, 16'h0002);
		st(40'h0000018000, DACC_STORE_RND, 1'b1, 1'b0, 16'h0002);
		st(40'h0000028000, DACC_STORE_RND, 1'b1, 1'b0, 16'h0002);
		st(40'h0000028000, DACC_STORE_RND, 1'b0, 1'b0, 16'h0003);
		st(40'h0100000000, DACC_STORE, 1'b0, 1'b0, 16'h0000);
		st(40'h0100000000, DACC_STORE, 1'b0, 1'b1, 16'h7FFF);
		st(40'hFF00000000, DACC_STORE, 1'b0, 1'b1, 16'h8000);
	endtask : sc_store
	task automatic sc_wb;
		@(posedge clk_in);
		ptr_wr_in <= 1'b1;
		round_mode_select_in <= 1'b0;
		@(posedge clk_in);
		ptr_wr_in <= 1'b0;
		wb_en_in <= 1'b1;
		wb_indirect_in <= 1'b1;
		do_op(DACC_LOAD, 1'b0, 40'h0000038000);
		do_op(DACC_MAC, 1'b1, 40'h0000000000);
		chk("wb strobe", 40'h1, {39'h0, mem_wr_out});
		chk("wb data", 40'h0004, {24'h0, mem_wdata_out});
		chk("wb addr", 40'h0100, {24'h0, mem_addr_out});
		chk("pointer", 40'h0102, {24'h0, write_back_pointer_register_out});
		do_op(DACC_MPY, 1'b1, 40'hF000001234);
		chk("no wb", 40'h0, {39'h0, mem_wr_out});
		chk("acc two", 40'hF000001234, accumulator_two_out);
		@(posedge clk_in);
		wb_indirect_in <= 1'b0;
		do_op(DACC_MAC, 1'b1, 40'h0000000000);
		chk("direct no write", 40'h0, {39'h0, mem_wr_out});
		chk("pointer", 40'h0004, {24'h0, write_back_pointer_register_out});
	endtask : sc_wb
	task automatic sc_shift;
		sh(1'b1, 1'b0, 1'b0, 6'sd4, 40'h0000040000);
		sh(1'b1, 1'b0, 1'b0, -6'sd16, 40'h0000400000);
		sh(1'b0, 1'b0, 1'b0, 6'sd0, 40'h0000038000);
		sh(1'b0, 1'b1, 1'b1, 6'sd4, 40'h0F00000123);
	endtask : sc_shift
	task automatic stop_test;
		$display("checks_done %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	initial
	begin
		repeat (20000) @(posedge clk_in);
		fails++;
		stop_test;
	end
	initial
	begin
		{clk_in, arst_n_in, op_valid_in, target_two_in, shift_src_x_in, shift_src_two_in} = '0;
		{shift_logical_in, load_shift_in, wb_en_in, wb_indirect_in, ptr_wr_in} = '0;
		{saturation_enable_one_in, saturation_enable_two_in, saturation_width_select_in} = '0;
		{round_mode_select_in, data_write_saturation_enable_in, overflow_trap_enable_one_in} = '0;
		{overflow_trap_enable_two_in, catastrophic_overflow_trap_enable_in} = '0;
		{sat_clear_one_in, sat_clear_two_in, shift_amt_in} = '0;
		{product_in, x_bus_in, ptr_wdata_in} = {40'h0, 16'h0040, 16'h0100};
		op_in = DACC_NOP;
		fails = 0;
		checks_done = 0;
		repeat (3) @(posedge clk_in);
		arst_n_in <= 1'b1;
		sc_sat40;
		sc_sat32;
		sc_wrap;
		sc_guard;
		sc_store;
		sc_wb;
		sc_shift;
		stop_test;
	end
endmodule : dacc_top_tb_top
`default_nettype wire
